// ### hw/pwmisp_top.sv
// PWM interrupt clear register, interrupt flags and script store write pointer.
//
// Behaviour
// - Write-only clear register at 0x7C removes selected pending PWM interrupts.
// - Clear bits 5, 4, 3 clear script-done of channels 2, 1, 0.
// - Clear bits 2, 1, 0 clear cycle-done of channels 2, 1, 0.
// - Writing 1 clears, 0 leaves alone; no write back to zero needed.
// - Channel cycle-done flag rises when its active command's PWM cycle ends.
// - Channel script-done flag rises when its pattern generator finishes a task.
// - Pointer register at 0x7D, readable and writable, picks next overwritten entry.
// - Pointer counts whole two-byte entries, never single byte positions.
// - Pointer advances by one per complete two-byte data write to a valid entry only.
// - Pointer 0-31 channel 0, 32-63 channel 1, 64-95 channel 2, rest invalid.
// - Entry arrives high byte then low byte at 0x7E, address not advancing.
// - Masked status is raw status gated by enables; only it drives interrupt.
`timescale 1ns/100ps
module pwmisp_top #(
  parameter int NUM_CH = pwmisp_pkg::CHANNELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Byte register port from the serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_xfer_end,
  output logic [7:0] reg_rdata,
  // Completion events from the PWM channels
  input wire logic [NUM_CH-1:0] cycle_done_event,
  input wire logic [NUM_CH-1:0] script_done_event,
  // Interrupt enables from the channel configuration bits
  input wire logic [NUM_CH-1:0] cycle_done_irq_en,
  input wire logic [NUM_CH-1:0] script_done_irq_en,
  // Interrupt status
  output logic [7:0] pwm_raw_irq_status,
  output logic [7:0] pwm_masked_irq_status,
  output logic irq_out,
  // Script store write port
  output logic store_wr,
  output logic [1:0] store_chan,
  output logic [4:0] store_slot,
  output logic [15:0] store_data,
  // Current write pointer
  output logic [6:0] script_write_pointer
);

  // The channel count is capped at MAX_CHANNELS, three, one short of the four a two-bit channel number could carry.
  if (NUM_CH < 1 || NUM_CH > pwmisp_pkg::MAX_CHANNELS) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 3");
  end

  // The pointer and the store index must reach every slot of every channel.
  if (pwmisp_pkg::SLOTS_PER_CH != (1 << pwmisp_pkg::SLOT_W) ||
      NUM_CH * pwmisp_pkg::SLOTS_PER_CH > (1 << pwmisp_pkg::PTR_W)) begin : g_bad_geometry
    $error("script store geometry does not fit the pointer");
  end

  localparam logic [7:0] PTR_LIMIT = 8'(NUM_CH * pwmisp_pkg::SLOTS_PER_CH);

  pwmisp_pkg::pwmisp_main_s st_ff;
  pwmisp_pkg::pwmisp_main_s nxt_st;

  logic clr_wr;
  logic ptr_wr;
  logic data_wr;
  logic ptr_valid;
  logic [7:0] clr_bits;
  logic [NUM_CH-1:0] cycle_done_irq;
  logic [NUM_CH-1:0] script_done_irq;
  logic [7:0] raw_v;
  logic [7:0] en_v;

  assign clr_wr = reg_wr && (reg_addr == pwmisp_pkg::ADDR_IRQ_CLEAR);
  assign ptr_wr = reg_wr && (reg_addr == pwmisp_pkg::ADDR_WR_PTR);
  assign data_wr = reg_wr && (reg_addr == pwmisp_pkg::ADDR_SCRIPT_DATA);
  assign clr_bits = clr_wr ? reg_wdata : 8'h00;
  assign ptr_valid = ({1'b0, st_ff.ptr} < PTR_LIMIT);

  // One sticky flag per channel and per interrupt kind.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    pwmisp_flag u_cyc (
      .clk(clk),
      .reset(reset),
      .set_evt(cycle_done_event[i]),
      .clr_req(clr_bits[pwmisp_pkg::CYC_BIT_LSB + i]),
      .flag(cycle_done_irq[i])
    );
    pwmisp_flag u_scr (
      .clk(clk),
      .reset(reset),
      .set_evt(script_done_event[i]),
      .clr_req(clr_bits[pwmisp_pkg::SCR_BIT_LSB + i]),
      .flag(script_done_irq[i])
    );
  end

  always_comb begin
    raw_v = 8'h00;
    en_v = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      raw_v[pwmisp_pkg::CYC_BIT_LSB + i] = cycle_done_irq[i];
      raw_v[pwmisp_pkg::SCR_BIT_LSB + i] = script_done_irq[i];
      en_v[pwmisp_pkg::CYC_BIT_LSB + i] = cycle_done_irq_en[i];
      en_v[pwmisp_pkg::SCR_BIT_LSB + i] = script_done_irq_en[i];
    end
  end

  // Masking is combinational so a disabled source drops the line in the same cycle.
  assign pwm_raw_irq_status = raw_v;
  assign pwm_masked_irq_status = raw_v & en_v;
  assign irq_out = |(raw_v & en_v);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.store_wr = 1'b0;
    // A pointer write drops a lone high byte, so one entry never spans two pointers.
    if (ptr_wr) begin
      nxt_st.ptr = reg_wdata[6:0];
      nxt_st.hi_pend = 1'b0;
    end else if (data_wr) begin
      if (!st_ff.hi_pend) begin
        nxt_st.hi_pend = 1'b1;
        nxt_st.hi_byte = reg_wdata;
      end else begin
        nxt_st.hi_pend = 1'b0;
        // An entry aimed past the last channel is dropped and the pointer holds.
        if (ptr_valid) begin
          nxt_st.store_wr = 1'b1;
          nxt_st.store_idx = st_ff.ptr;
          nxt_st.store_data = {st_ff.hi_byte, reg_wdata};
          nxt_st.ptr = st_ff.ptr + 7'h01;
        end
      end
    end
    // A lone high byte left when the transaction ends is discarded.
    if (reg_xfer_end) begin
      nxt_st.hi_pend = 1'b0;
    end
    // Read data is registered, so it trails the address by one cycle.
    case (reg_addr)
      pwmisp_pkg::ADDR_WR_PTR: nxt_st.rdata = {1'b0, st_ff.ptr};
      default: nxt_st.rdata = pwmisp_pkg::BYTE_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '{ptr: pwmisp_pkg::PTR_RST, hi_pend: 1'b0, hi_byte: pwmisp_pkg::BYTE_RST,
                 store_wr: 1'b0, store_idx: pwmisp_pkg::PTR_RST,
                 store_data: pwmisp_pkg::WORD_RST, rdata: pwmisp_pkg::BYTE_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  // The store port keeps its last entry between strobes, which lets a slow store latch late.
  assign store_wr = st_ff.store_wr;
  assign store_chan = st_ff.store_idx[6:5];
  assign store_slot = st_ff.store_idx[4:0];
  assign store_data = st_ff.store_data;
  assign script_write_pointer = st_ff.ptr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] ev_v;
  always_comb begin
    ev_v = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      ev_v[pwmisp_pkg::CYC_BIT_LSB + i] = cycle_done_event[i];
      ev_v[pwmisp_pkg::SCR_BIT_LSB + i] = script_done_event[i];
    end
  end

  sequence seq_hi_byte;
    data_wr && !st_ff.hi_pend && !reg_xfer_end && ptr_valid;
  endsequence

  sequence seq_lo_byte;
    data_wr;
  endsequence

  // A complete word is a valid high byte followed at once by its low byte.
  sequence seq_word;
    seq_hi_byte ##1 seq_lo_byte;
  endsequence

  // Clear and event behaviour of the flags, then pointer writes and entry stores.
  AST_CLEAR_CYC: assert property (
    clr_wr |=> (pwm_raw_irq_status[2:0] & $past(reg_wdata[2:0]) & ~$past(ev_v[2:0])) == 3'h0)
    else $error("cycle-done flag survived a clear write");

  AST_CLEAR_SCR: assert property (
    clr_wr |=> (pwm_raw_irq_status[5:3] & $past(reg_wdata[5:3]) & ~$past(ev_v[5:3])) == 3'h0)
    else $error("script-done flag survived a clear write");

  AST_CLEAR_ZERO_KEEPS: assert property (
    clr_wr |=> (pwm_raw_irq_status & $past(pwm_raw_irq_status) & ~$past(reg_wdata))
               == ($past(pwm_raw_irq_status) & ~$past(reg_wdata)))
    else $error("zero bit in clear write removed a flag");

  AST_EVENT_SETS: assert property (
    1'b1 |=> (pwm_raw_irq_status & $past(ev_v)) == $past(ev_v))
    else $error("completion event did not set its flag");

  AST_SET_WINS: assert property (
    (clr_wr && (reg_wdata & ev_v) != 8'h00) |=>
      (pwm_raw_irq_status & $past(reg_wdata) & $past(ev_v))
      == ($past(reg_wdata) & $past(ev_v)))
    else $error("event lost against a simultaneous clear");

  AST_FLAGS_QUIET: assert property (
    (!clr_wr && ev_v == 8'h00) |=> $stable(pwm_raw_irq_status))
    else $error("status changed without event or clear");

  AST_MASKED: assert property (
    pwm_masked_irq_status == (pwm_raw_irq_status & en_v) && irq_out == |pwm_masked_irq_status)
    else $error("masked status or interrupt disagrees with raw status");

  AST_RESERVED_ZERO: assert property (
    pwm_raw_irq_status[7:6] == 2'b00)
    else $error("reserved status bits set");

  AST_PTR_WRITE: assert property (
    ptr_wr |=> script_write_pointer == $past(reg_wdata[6:0]) ##1
               (reg_addr != pwmisp_pkg::ADDR_WR_PTR || $past(reg_addr) != reg_addr ||
                reg_rdata == {1'b0, $past(script_write_pointer)}))
    else $error("pointer write or readback wrong");

  AST_WORD_ADVANCE: assert property (
    seq_hi_byte ##1 seq_lo_byte |=> store_wr && script_write_pointer == $past(st_ff.ptr, 2)
                                   + 7'h01 && store_data[15:8] == $past(reg_wdata, 2))
    else $error("complete word did not write entry and advance pointer");

  AST_SINGLE_NO_ADV: assert property (
    (data_wr && !st_ff.hi_pend) |=> !store_wr && $stable(script_write_pointer))
    else $error("single byte advanced the pointer");

  AST_VALID_TARGET: assert property (
    store_wr |-> store_chan != 2'b11 && {1'b0, store_chan, store_slot} < PTR_LIMIT)
    else $error("entry written past the last channel");

  AST_STROBE_ONE: assert property (
    store_wr |=> !store_wr)
    else $error("store strobe held for two cycles");

  // Pairing and pointer movement.
  AST_LONE_DROPPED: assert property (
    (data_wr && !st_ff.hi_pend && reg_xfer_end) |=> !st_ff.hi_pend)
    else $error("lone high byte survived the transaction end");

  AST_HIGH_HELD: assert property (
    (data_wr && !st_ff.hi_pend && !reg_xfer_end) |=> st_ff.hi_pend)
    else $error("high byte was not held for its low byte");

  AST_PTR_WR_DROPS: assert property (
    ptr_wr |=> !st_ff.hi_pend)
    else $error("pointer write kept a lone high byte");

  AST_INVALID_HOLDS: assert property (
    (data_wr && st_ff.hi_pend && !ptr_valid) |=> !store_wr && $stable(script_write_pointer))
    else $error("entry past the last channel stored or moved the pointer");

  AST_PTR_QUIET: assert property (
    (!ptr_wr && !data_wr) |=> $stable(script_write_pointer))
    else $error("pointer moved without a register write");

  AST_NO_STORE_IDLE: assert property (
    !data_wr |=> !store_wr)
    else $error("store strobe without a data byte");

  AST_LOW_PAIRS: assert property (
    store_wr |-> $past(data_wr) && $past(st_ff.hi_pend))
    else $error("store strobe without a completed pair");

  AST_STORE_INDEX: assert property (
    seq_word |=> {store_chan, store_slot} == $past(st_ff.ptr, 2))
    else $error("entry stored away from the pointer");

  AST_STORE_LOW: assert property (
    seq_word |=> store_data[7:0] == $past(reg_wdata))
    else $error("low byte of entry wrong");

  AST_DATA_HOLDS: assert property (
    1'b1 |=> store_wr || $stable(store_data))
    else $error("store data changed without a strobe");

  // Readback and interrupt line.
  AST_RDATA_PTR: assert property (
    (reg_addr == pwmisp_pkg::ADDR_WR_PTR) |=> reg_rdata == {1'b0, $past(script_write_pointer)})
    else $error("pointer readback wrong");

  AST_READ_ZERO: assert property (
    (reg_addr != pwmisp_pkg::ADDR_WR_PTR) |=> reg_rdata == 8'h00)
    else $error("register other than the pointer read nonzero");

  AST_IRQ_FOLLOWS: assert property (
    (pwm_masked_irq_status != 8'h00) |-> irq_out)
    else $error("masked source did not raise the interrupt");

endmodule

// ### hw/pwmisp_pkg.sv
// Package with offsets, field positions, reset values and state types of the PWM interrupt block.
package pwmisp_pkg;

  // Register byte addresses on the serial slave's register port.
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h7C;
  localparam logic [7:0] ADDR_WR_PTR = 8'h7D;
  localparam logic [7:0] ADDR_SCRIPT_DATA = 8'h7E;

  // Field positions inside the clear and status bytes.
  localparam int CYC_BIT_LSB = 0;
  localparam int SCR_BIT_LSB = 3;

  // Channel and script store geometry.
  localparam int CHANNELS = 3;
  localparam int MAX_CHANNELS = 3;
  localparam int PTR_W = 7;
  localparam int SLOT_W = 5;
  localparam int SLOTS_PER_CH = 32;

  // Values after reset.
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // State of one sticky interrupt flag.
  typedef struct packed {
    logic pend;
  } pwmisp_flag_s;

  // State of the register and script pointer logic.
  typedef struct packed {
    logic [6:0] ptr;
    logic hi_pend;
    logic [7:0] hi_byte;
    logic store_wr;
    logic [6:0] store_idx;
    logic [15:0] store_data;
    logic [7:0] rdata;
  } pwmisp_main_s;

endpackage

// ### hw/pwmisp_flag.sv
// One sticky interrupt pending flag with set-over-clear priority.
`timescale 1ns/100ps
module pwmisp_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Event and clear request
  input wire logic set_evt,
  input wire logic clr_req,
  // Pending state
  output logic flag
);

  pwmisp_pkg::pwmisp_flag_s st_ff;
  pwmisp_pkg::pwmisp_flag_s nxt_st;

  // A new event in the clearing cycle survives, so no completion is ever lost.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pend = set_evt | (st_ff.pend & ~clr_req);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.pend;

endmodule

// ### tb/pwmisp_host.sv
// Host model that writes and reads the byte register port of the PWM interrupt block.
`timescale 1ns/100ps
module pwmisp_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_xfer_end
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_xfer_end = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic last);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_xfer_end = last;
    @(posedge clk);
    #1;
  endtask
  // Released data is inverted so a stale byte can never look valid.
  task automatic drop();
    reg_wr = 1'b0;
    reg_xfer_end = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  // wr8, wr16 and rd wait an edge first, so a strobe is never lowered and raised in one step.
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    put(a, d, 1'b1);
    drop();
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    put(a, d[15:8], 1'b0);
    put(a, d[7:0], 1'b1);
    drop();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    @(posedge clk);
    #1;
  endtask
endmodule

// ### tb/pwmisp_top_bench.sv
// Self-checking bench for the PWM interrupt clear and script pointer block.
`timescale 1ns/100ps
module pwmisp_top_bench;
  typedef struct packed {
    logic [2:0] cyc, scr, cen, sen;
    logic [7:0] clr, raw, msk, aft;
  } pwmisp_row_s;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] cyc_ev = 3'h0, scr_ev = 3'h0, cyc_en = 3'h7, scr_en = 3'h7;
  logic reg_wr, reg_xfer_end, irq_out, store_wr;
  logic [7:0] reg_addr, reg_wdata, rdata, raw, masked;
  logic [1:0] store_chan;
  logic [4:0] store_slot;
  logic [15:0] store_data;
  logic [6:0] ptr;
  int mismatches = 0;
  int checked = 0;
  pwmisp_row_s rows [6] = '{
    '{3'h7, 3'h0, 3'h7, 3'h0, 8'h01, 8'h07, 8'h07, 8'h06},
    '{3'h0, 3'h7, 3'h0, 3'h7, 8'h08, 8'h38, 8'h38, 8'h30},
    '{3'h7, 3'h7, 3'h2, 3'h4, 8'h24, 8'h3F, 8'h22, 8'h1B},
    '{3'h7, 3'h7, 3'h0, 3'h0, 8'h12, 8'h3F, 8'h00, 8'h2D},
    '{3'h5, 3'h2, 3'h7, 3'h7, 8'hC0, 8'h15, 8'h15, 8'h15},
    '{3'h7, 3'h7, 3'h7, 3'h7, 8'h3F, 8'h3F, 8'h3F, 8'h00}};
  always #4 clk = ~clk;
  pwmisp_host host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_xfer_end(reg_xfer_end));
  pwmisp_top #(.NUM_CH(3)) dut (.clk(clk), .reset(reset), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_xfer_end(reg_xfer_end),
    .reg_rdata(rdata), .cycle_done_event(cyc_ev), .script_done_event(scr_ev),
    .cycle_done_irq_en(cyc_en), .script_done_irq_en(scr_en), .pwm_raw_irq_status(raw),
    .pwm_masked_irq_status(masked), .irq_out(irq_out), .store_wr(store_wr),
    .store_chan(store_chan), .store_slot(store_slot), .store_data(store_data),
    .script_write_pointer(ptr));
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic evt(input logic [2:0] c, input logic [2:0] s);
    @(posedge clk);
    #1;
    cyc_ev = c;
    scr_ev = s;
    @(posedge clk);
    #1;
    cyc_ev = 3'h0;
    scr_ev = 3'h0;
  endtask
  task automatic chk_rst();
    chk8("raw", 8'h00, raw);
    chk8("ptr", 8'h00, {1'b0, ptr});
    chk8("rdata", 8'h00, rdata);
    chk1("store_wr", 1'b0, store_wr);
    chk1("irq_out", 1'b0, irq_out);
  endtask
  task automatic chk_store(input logic [7:0] idx, input logic [15:0] d, input logic [7:0] nxt);
    chk1("store_wr", 1'b1, store_wr);
    chk8("store index", idx, {1'b0, store_chan, store_slot});
    chk8("data high", d[15:8], store_data[15:8]);
    chk8("data low", d[7:0], store_data[7:0]);
    chk8("ptr", nxt, {1'b0, ptr});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    chk_rst();
    foreach (rows[i]) begin
      cyc_en = rows[i].cen;
      scr_en = rows[i].sen;
      evt(rows[i].cyc, rows[i].scr);
      chk8("raw", rows[i].raw, raw);
      chk8("masked", rows[i].msk, masked);
      chk1("irq_out", rows[i].msk != 8'h00, irq_out);
      host.wr8(pwmisp_pkg::ADDR_IRQ_CLEAR, rows[i].clr);
      chk8("raw cleared", rows[i].aft, raw);
      host.wr8(pwmisp_pkg::ADDR_IRQ_CLEAR, 8'hFF);
    end
    fork
      host.wr8(pwmisp_pkg::ADDR_IRQ_CLEAR, 8'h01);
      evt(3'h1, 3'h0);
    join
    chk8("raw set wins", 8'h01, raw);
    host.wr8(pwmisp_pkg::ADDR_WR_PTR, 8'h1F);
    host.rd(pwmisp_pkg::ADDR_WR_PTR);
    chk8("ptr read", 8'h1F, rdata);
    host.rd(pwmisp_pkg::ADDR_IRQ_CLEAR);
    chk8("clear read", 8'h00, rdata);
    host.wr16(pwmisp_pkg::ADDR_SCRIPT_DATA, 16'hA55A);
    chk_store(8'h1F, 16'hA55A, 8'h20);
    // A lone byte closed by the transaction end must neither store nor advance.
    host.wr8(pwmisp_pkg::ADDR_SCRIPT_DATA, 8'h12);
    chk1("lone store_wr", 1'b0, store_wr);
    chk8("lone ptr", 8'h20, {1'b0, ptr});
    host.wr16(pwmisp_pkg::ADDR_SCRIPT_DATA, 16'hB00C);
    chk_store(8'h20, 16'hB00C, 8'h21);
    host.wr8(pwmisp_pkg::ADDR_WR_PTR, 8'h5F);
    host.wr16(pwmisp_pkg::ADDR_SCRIPT_DATA, 16'h0FF0);
    chk_store(8'h5F, 16'h0FF0, 8'h60);
    host.wr16(pwmisp_pkg::ADDR_SCRIPT_DATA, 16'h1234);
    chk1("invalid store_wr", 1'b0, store_wr);
    chk8("invalid ptr", 8'h60, {1'b0, ptr});
    // A high byte left open before a pointer write must not pair with the next word.
    @(posedge clk);
    #1;
    host.put(pwmisp_pkg::ADDR_SCRIPT_DATA, 8'h77, 1'b0);
    host.drop();
    chk1("open store_wr", 1'b0, store_wr);
    host.wr8(pwmisp_pkg::ADDR_WR_PTR, 8'h10);
    host.wr16(pwmisp_pkg::ADDR_SCRIPT_DATA, 16'hCAFE);
    chk_store(8'h10, 16'hCAFE, 8'h11);
    evt(3'h7, 3'h7);
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    chk_rst();
    complete_run();
  end
  initial begin
    #10000;
    mismatches++;
    complete_run();
  end
endmodule
